// [tap_pkg.sv]
// shared constants of the boundary scan port and its controller
// How it works
// - one-bit bypass path, cleared on capture
// - capture loads pin ring, shift links chain
// - chain covers all pins plus spare cells
// - tdi enters msb, lsb drives tdo
// - id instruction captures and shifts fixed code
// - instruction register is three bits wide
// - controller refuses ir commands whose low three tx bits hold a reserved code
// - shift in ir, make current at update-ir
// - id instruction current at reset and logic-reset
// - float-sample links chain and floats data outputs
// - sample snapshots pins without disturbing memory
// - test clock no faster than 20 mhz
// - unstable pins may capture unpredictable values
// - update-dr latches shifted pattern into outputs
// - sample out and preload in together
// - bypass links only the single bit
// - extest drives latched values, chain in shift
// - cell 47 enables outputs under extest
// - float control latch preset at logic-reset
// - sample on tck rise, tdo on fall
// - codes: extest 000, id 001, float 010
// - sample 100, bypass 111, others reserved
// - capture-ir loads 01 into low bits
package tap_pkg;
  localparam int IR_W = 3;
  localparam int BSR_W = 107;
  localparam int ID_W = 32;
  localparam int FLOAT_CELL = 47;
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_IDCODE = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] OP_RSV_A = 3'h3;
  localparam logic [2:0] OP_SAMPLE = 3'h4;
  localparam logic [2:0] OP_RSV_B = 3'h5;
  localparam logic [2:0] OP_RSV_C = 3'h6;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // arbitrary identification value; only bit 0 (register present) is meaningful
  localparam logic [ID_W-1:0] ID_CODE = 32'h0123_4001;
  localparam logic [BSR_W-1:0] UPD_RESET =
    {{(BSR_W - FLOAT_CELL - 1){1'b0}}, 1'b1, {FLOAT_CELL{1'b0}}};
  // timing
  localparam int CORE_PERIOD_NS = 40;
  localparam int TCK_MAX_MHZ = 20;
  localparam int TCK_MIN_PERIOD_NS = 1000 / TCK_MAX_MHZ;
  localparam int HOST_TCK_PERIOD_NS = 320;
  localparam int TCK_HALF_CYC = (HOST_TCK_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // controller command kinds and sequences (tms patterns lsb first)
  localparam logic [1:0] KIND_RESET = 2'h0;
  localparam logic [1:0] KIND_IR = 2'h1;
  localparam logic [1:0] KIND_DR = 2'h2;
  localparam logic [7:0] PRE_RESET_N = 8'h06;
  localparam logic [7:0] PRE_IR_N = 8'h04;
  localparam logic [7:0] PRE_DR_N = 8'h03;
  localparam logic [7:0] POST_N = 8'h02;
  localparam logic [5:0] PRE_RESET_PAT = 6'h1f;
  localparam logic [5:0] PRE_IR_PAT = 6'h03;
  localparam logic [5:0] PRE_DR_PAT = 6'h01;
  localparam logic [1:0] POST_PAT = 2'h1;
  // controller registers over apb
  localparam int DW = 32;
  localparam int AW = 12;
  localparam int BUF_W = 128;
  localparam logic [AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [AW-1:0] OFF_STATUS = 12'h004;
  localparam logic [AW-1:0] OFF_TX = 12'h010;
  localparam logic [AW-1:0] OFF_RX = 12'h020;
  localparam logic [AW-1:0] WORD_SEL_MASK = 12'h00c;
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
endpackage : tap_pkg

// [tap_link_if.sv]
// serial test link between the controller and the boundary scan port
`timescale 1ns/1ns
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_wire;
  // undriven tdo floats; model the pull-up
  assign tdo_wire = tdo_oe_n ? 1'b1 : tdo;
  modport tap_end (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
  modport ctl_end (output tck, output tms, output tdi, input tdo_wire);
endinterface : tap_link_if

// [sram_tap.sv]
// boundary scan test access port of the memory
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module sram_tap
  import tap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // serial test link
  tap_link_if.tap_end link,
  // memory pin ring
  input wire logic [BSR_W-1:0] ring_in,
  output logic [BSR_W-1:0] ring_out,
  output logic extest_on,
  output logic data_hiz
);

  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic [1:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic tck_last;
    tap_state_t st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] upd;
    logic tdo;
    logic tdo_oe_n;
    logic extest;
    logic hiz;
  } tap_regs_t;

  tap_regs_t q;
  tap_regs_t d;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = ST_TLR;
    case (s)
      ST_TLR: n = tms ? ST_TLR : ST_IDLE;
      ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
      default: n = ST_TLR;
    endcase
    return n;
  endfunction : tap_next

  logic rise;
  logic fall;
  logic tms_in;
  logic tdi_in;
  logic sel_bsr;
  logic sel_id;
  logic shifting;

  always_comb begin
    d = q;
    // link pins cross in through two flops each
    d.tck_s = {q.tck_s[0], link.tck};
    d.tms_s = {q.tms_s[0], link.tms};
    d.tdi_s = {q.tdi_s[0], link.tdi};
    d.tck_last = q.tck_s[1];
    rise = q.tck_s[1] & ~q.tck_last;
    fall = ~q.tck_s[1] & q.tck_last;
    tms_in = q.tms_s[1];
    tdi_in = q.tdi_s[1];
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    case (q.ir)
      OP_EXTEST: begin
        sel_bsr = 1'b1;
      end
      OP_IDCODE: begin
        sel_id = 1'b1;
      end
      OP_SAMPLE_Z: begin
        sel_bsr = 1'b1;
      end
      OP_SAMPLE: begin
        sel_bsr = 1'b1;
      end
      OP_BYPASS: begin
        sel_id = 1'b0;
      end
      // reserved codes fall through to the bypass bit so a stray load cannot break the chain
      default: begin
        sel_bsr = 1'b0;
      end
    endcase
    shifting = (q.st == ST_SH_IR) || (q.st == ST_SH_DR);

    if (rise) begin
      d.st = tap_next(q.st, tms_in);
      case (q.st)
        ST_CAP_IR: begin
          d.ir_sh = IR_CAPTURE;
        end
        ST_SH_IR: begin
          d.ir_sh = {tdi_in, q.ir_sh[IR_W-1:1]};
        end
        ST_UPD_IR: begin
          d.ir = q.ir_sh;
        end
        ST_CAP_DR: begin
          if (sel_bsr) begin
            // the float cell has no pin; it reads back its own latch
            d.bsr = ring_in;
            d.bsr[FLOAT_CELL] = q.upd[FLOAT_CELL];
          end else if (sel_id) begin
            d.id_sh = ID_CODE;
          end else begin
            d.byp = 1'b0;
          end
        end
        ST_SH_DR: begin
          if (sel_bsr) begin
            d.bsr = {tdi_in, q.bsr[BSR_W-1:1]};
          end else if (sel_id) begin
            d.id_sh = {tdi_in, q.id_sh[ID_W-1:1]};
          end else begin
            d.byp = tdi_in;
          end
        end
        ST_UPD_DR: begin
          if (sel_bsr) begin
            d.upd = q.bsr;
          end
        end
        default: begin
        end
      endcase
    end

    // held for as long as the controller sits in logic-reset
    if (q.st == ST_TLR) begin
      d.ir = OP_IDCODE;
      d.upd[FLOAT_CELL] = 1'b1;
    end

    if (fall) begin
      // moving tdo a half period early gives the far end a settled bit at its rise
      d.tdo_oe_n = ~shifting;
      if (q.st == ST_SH_IR) begin
        d.tdo = q.ir_sh[0];
      end else if (sel_bsr) begin
        d.tdo = q.bsr[0];
      end else if (sel_id) begin
        d.tdo = q.id_sh[0];
      end else begin
        d.tdo = q.byp;
      end
    end

    // output drive follows the current instruction; sampling never touches it
    d.extest = (q.ir == OP_EXTEST);
    d.hiz = (q.ir == OP_SAMPLE_Z) || ((q.ir == OP_EXTEST) && !q.upd[FLOAT_CELL]);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= ST_TLR;
      q.ir <= OP_IDCODE;
      q.upd <= UPD_RESET;
      q.tdo_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.tdo = q.tdo;
  assign link.tdo_oe_n = q.tdo_oe_n;
  assign ring_out = q.upd;
  assign extest_on = q.extest;
  assign data_hiz = q.hiz;

endmodule : sram_tap

// [tap_master.sv]
// boundary scan test controller with apb command registers
`timescale 1ns/1ns
module tap_master
  import tap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial test link
  tap_link_if.ctl_end link
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_RUN = 2'b10
  } host_state_t;

  typedef struct packed {
    logic tms;
    logic tdi;
    logic shift;
    logic [6:0] idx;
  } emit_t;

  typedef struct packed {
    host_state_t st;
    logic [3:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic [7:0] step;
    logic [7:0] total;
    logic [1:0] kind;
    logic [6:0] len;
    logic smp;
    logic [6:0] smp_idx;
    logic [1:0] tdo_s;
    logic [BUF_W-1:0] tx;
    logic [BUF_W-1:0] rx;
    logic done;
    logic err;
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } host_regs_t;

  localparam logic [3:0] HALF_LAST = 4'(TCK_HALF_CYC - 1);

  host_regs_t q;
  host_regs_t d;

  function automatic emit_t emit(input logic [7:0] s, input logic [1:0] kind,
                                 input logic [6:0] len, input logic [BUF_W-1:0] tx);
    emit_t e;
    logic [7:0] pre;
    logic [7:0] rel;
    logic [5:0] pat;
    e = '0;
    pre = (kind == KIND_RESET) ? PRE_RESET_N : (kind == KIND_IR) ? PRE_IR_N : PRE_DR_N;
    pat = (kind == KIND_RESET) ? PRE_RESET_PAT : (kind == KIND_IR) ? PRE_IR_PAT : PRE_DR_PAT;
    rel = s - pre;
    if (s < pre) begin
      e.tms = pat[s[2:0]];
    end else if (rel < {1'b0, len}) begin
      e.idx = rel[6:0];
      e.tdi = tx[rel[6:0]];
      e.tms = (rel == {1'b0, len} - 8'h01);
      e.shift = 1'b1;
    end else begin
      rel = rel - {1'b0, len};
      e.tms = POST_PAT[rel[0]];
    end
    return e;
  endfunction : emit

  logic setup;
  logic wr;
  logic busy;
  logic is_ctrl;
  logic is_stat;
  logic is_tx;
  logic is_rx;
  logic [1:0] word;
  logic [1:0] c_kind;
  logic [6:0] c_len;
  logic bad;
  logic [DW-1:0] rd;
  emit_t e;

  always_comb begin
    d = q;
    d.tdo_s = {q.tdo_s[0], link.tdo_wire};
    busy = (q.st == H_RUN);
    setup = psel & ~penable;
    word = paddr[3:2];
    is_ctrl = (paddr == OFF_CTRL);
    is_stat = (paddr == OFF_STATUS);
    is_tx = ((paddr & ~WORD_SEL_MASK) == OFF_TX);
    is_rx = ((paddr & ~WORD_SEL_MASK) == OFF_RX);
    wr = psel & penable & q.pready & pwrite & ~q.pslverr;
    c_kind = pwdata[CTRL_KIND_LSB +: 2];
    c_len = pwdata[CTRL_LEN_LSB +: 7];
    // reserved kinds, impossible lengths and reserved codes in tx[2:0] of ir commands never reach the link
    bad = busy || (c_kind != KIND_RESET && c_kind != KIND_IR && c_kind != KIND_DR) ||
          (c_kind != KIND_RESET && (c_len == 7'h00 || c_len > 7'(BSR_W))) ||
          (c_kind == KIND_IR && (q.tx[2:0] == OP_RSV_A || q.tx[2:0] == OP_RSV_B ||
                                 q.tx[2:0] == OP_RSV_C));
    e = emit(8'h00, c_kind, c_len, q.tx);

    rd = '0;
    if (is_ctrl) begin
      rd[CTRL_KIND_LSB +: 2] = q.kind;
      rd[CTRL_LEN_LSB +: 7] = q.len;
    end else if (is_stat) begin
      rd[ST_BUSY] = busy;
      rd[ST_DONE] = q.done;
      rd[ST_ERR] = q.err;
    end else if (is_tx) begin
      rd = q.tx[word * DW +: DW];
    end else if (is_rx) begin
      rd = q.rx[word * DW +: DW];
    end
    d.pready = setup;
    d.pslverr = setup & ~(is_ctrl | is_stat | is_tx | is_rx);
    d.prdata = (setup & ~pwrite) ? rd : '0;

    if (wr && is_stat) begin
      d.done = q.done & ~pwdata[ST_DONE];
      d.err = q.err & ~pwdata[ST_ERR];
    end
    if (wr && is_tx && !busy) begin
      d.tx[word * DW +: DW] = pwdata;
    end
    if (wr && is_ctrl) begin
      if (bad) begin
        d.err = 1'b1;
      end else begin
        d.st = H_RUN;
        d.kind = c_kind;
        d.len = c_len;
        d.total = (c_kind == KIND_RESET) ? PRE_RESET_N :
                  ((c_kind == KIND_IR) ? PRE_IR_N : PRE_DR_N) + {1'b0, c_len} + POST_N;
        d.step = 8'h01;
        d.div = '0;
        d.tck = 1'b0;
        d.tms = e.tms;
        d.tdi = e.tdi;
        d.smp = e.shift;
        d.smp_idx = e.idx;
      end
    end

    if (busy) begin
      e = emit(q.step, q.kind, q.len, q.tx);
      if (q.div == HALF_LAST) begin
        d.div = '0;
        d.tck = ~q.tck;
        if (q.tck) begin
          // tdo has been steady since the previous fall
          if (q.smp) begin
            d.rx[q.smp_idx] = q.tdo_s[1];
          end
          if (q.step == q.total) begin
            d.st = H_IDLE;
            d.done = 1'b1;
            d.tms = 1'b0;
            d.tdi = 1'b0;
            d.smp = 1'b0;
          end else begin
            d.tms = e.tms;
            d.tdi = e.tdi;
            d.smp = e.shift;
            d.smp_idx = e.idx;
            d.step = q.step + 8'h01;
          end
        end
      end else begin
        d.div = q.div + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.tck = q.tck;
  assign link.tms = q.tms;
  assign link.tdi = q.tdi;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

endmodule : tap_master

// [tap_link_sva.sv]
// assertions on the serial test link between the controller and the port
`timescale 1ns/1ns
module tap_link_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // serial test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic tdo_wire
);
  // next tap state for tms low and high, one nibble per state
  localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
  localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
  localparam logic [3:0] SH_DR = 4'h4;
  localparam logic [3:0] CAP_IR = 4'ha;
  localparam logic [3:0] SH_IR = 4'hb;
  logic tck_q;
  logic [3:0] st_q;
  logic [3:0] prv_q;
  logic [3:0] pp_q;
  logic shift_prv;
  assign shift_prv = (prv_q == SH_DR) || (prv_q == SH_IR);
  // tracks the controller's tms at each tck rise; the port lags by its input sync
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tck_q <= 1'b0;
      st_q <= 4'h0;
      prv_q <= 4'h0;
      pp_q <= 4'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q) begin
        st_q <= tms ? NX1[{st_q, 2'b00} +: 4] : NX0[{st_q, 2'b00} +: 4];
        prv_q <= st_q;
        pp_q <= prv_q;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_tms_on_fall: assert property ($changed(tms) |-> !tck)
    else $error("tms changed in tck high phase");
  a_tdi_on_fall: assert property ($changed(tdi) |-> !tck)
    else $error("tdi changed in tck high phase");
  a_tck_high_len: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("tck high phase not four cycles");
  a_tck_low_len: assert property ($fell(tck) |-> !tck [*4])
    else $error("tck low phase too short");
  a_tdo_steady_high: assert property (tck && $past(tck) && $past(tck, 2) |-> $stable(tdo))
    else $error("tdo moved in tck high phase");
  a_oe_after_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 2))
    else $error("tdo enable moved away from tck fall");
  a_oe_shift_only: assert property ($fell(tck) |-> tdo_oe_n == !shift_prv)
    else $error("tdo enable does not follow shift states");
  a_ir_capture_lsb: assert property ($fell(tck) && prv_q == SH_IR && pp_q == CAP_IR |-> tdo_wire)
    else $error("first instruction bit out is not one");
  c_dr_shift: cover property ($fell(tck) && prv_q == SH_DR);
  c_ir_shift: cover property ($fell(tck) && prv_q == SH_IR && pp_q == CAP_IR);
  c_logic_reset: cover property ($changed(st_q) && st_q == 4'h0);
endmodule : tap_link_sva

// [sram_boundary_scan_tap_tb_top.sv]
// self-checking bench of the boundary scan port driven by its controller
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module sram_boundary_scan_tap_tb_top
  import tap_pkg::*;
;
  localparam logic [BSR_W-1:0] PAT_IN = {3'h5, {13{8'h3c}}};
  // preload pattern keeps cell 47 low so the float control is exercised
  localparam logic [BSR_W-1:0] PAT_PRE = {3'h2, {13{8'h69}}};
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, perr;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, st;
  logic [BSR_W-1:0] ring_in, ring_out;
  logic extest_on, data_hiz;
  logic [BUF_W-1:0] rx;
  logic [IR_W-1:0] rsv [3];
  int mismatches, check_count;
  tap_link_if link();
  sram_tap i_sram_tap (.core_clk(core_clk), .reset(reset), .link(link.tap_end),
    .ring_in(ring_in), .ring_out(ring_out), .extest_on(extest_on), .data_hiz(data_hiz));
  tap_master i_tap_master (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.ctl_end));
  tap_link_sva i_tap_link_sva (.core_clk(core_clk), .reset(reset), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n),
    .tdo_wire(link.tdo_wire));
  initial begin
    core_clk = 1'b0;
    forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  function automatic logic [BSR_W-1:0] cap(input logic [BSR_W-1:0] p, input logic b);
    cap = p;
    cap[FLOAT_CELL] = b;
  endfunction : cap
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                     output logic [DW-1:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait-state limit here; the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] r);
    apb(1'b0, a, '0, r);
  endtask : rd
  // one controller command; a scan that never finishes is left to the watchdog
  task automatic scan(input logic [1:0] kind, input int len, input logic [BUF_W-1:0] tx,
                      output logic [BUF_W-1:0] rxd);
    logic [DW-1:0] d;
    for (int i = 0; i < 4; i++) wr(OFF_TX + AW'(4 * i), tx[32 * i +: 32]);
    wr(OFF_CTRL, DW'(kind) | (DW'(len) << CTRL_LEN_LSB));
    d = '0;
    while (d[ST_DONE] !== 1'b1) begin
      rd(OFF_STATUS, d);
    end
    `CHK(d[ST_ERR:ST_DONE], 2'b01)
    for (int i = 0; i < 4; i++) begin
      rd(OFF_RX + AW'(4 * i), d);
      rxd[32 * i +: 32] = d;
    end
    wr(OFF_STATUS, 32'h0000_0006);
  endtask : scan
  task automatic ir(input logic [IR_W-1:0] op);
    scan(KIND_IR, IR_W, BUF_W'(op), rx);
    `CHK(rx[IR_W-1:0], IR_CAPTURE)
  endtask : ir
  initial begin
    #(CORE_PERIOD_NS * 60000);
    mismatches++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ring_in = PAT_IN;
    mismatches = 0;
    check_count = 0;
    rsv = '{OP_RSV_A, OP_RSV_B, OP_RSV_C};
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    `CHK(ring_out, UPD_RESET)
    `CHK({extest_on, data_hiz}, 2'b00)
    scan(KIND_RESET, 0, '0, rx);
    scan(KIND_DR, ID_W, '0, rx);
    `CHK(rx[ID_W-1:0], ID_CODE)
    ir(OP_SAMPLE);
    scan(KIND_DR, BSR_W, BUF_W'(PAT_PRE), rx);
    `CHK(rx[BSR_W-1:0], cap(PAT_IN, 1'b1))
    `CHK(ring_out, PAT_PRE)
    `CHK({extest_on, data_hiz}, 2'b00)
    ir(OP_EXTEST);
    `CHK({extest_on, data_hiz}, 2'b11)
    scan(KIND_RESET, 0, '0, rx);
    `CHK(ring_out[FLOAT_CELL], 1'b1)
    `CHK({extest_on, data_hiz}, 2'b00)
    ring_in <= ~PAT_IN; // pins move only between captures
    ir(OP_EXTEST);
    scan(KIND_DR, BSR_W, BUF_W'(~PAT_PRE), rx);
    `CHK(rx[BSR_W-1:0], cap(~PAT_IN, 1'b1))
    `CHK(ring_out, ~PAT_PRE)
    `CHK({extest_on, data_hiz}, 2'b10)
    ir(OP_SAMPLE_Z);
    `CHK({extest_on, data_hiz}, 2'b01)
    scan(KIND_DR, BSR_W, BUF_W'(~PAT_PRE), rx);
    `CHK(rx[BSR_W-1:0], cap(~PAT_IN, 1'b1))
    ir(OP_BYPASS);
    `CHK(data_hiz, 1'b0)
    scan(KIND_DR, 8, BUF_W'(8'ha5), rx);
    `CHK(rx[7:0], 8'h4a)
    for (int i = 0; i < 3; i++) begin
      wr(OFF_TX, DW'(rsv[i]));
      wr(OFF_CTRL, DW'(KIND_IR) | (DW'(IR_W) << CTRL_LEN_LSB));
      rd(OFF_STATUS, st);
      `CHK(st[ST_ERR:ST_BUSY], 3'b100)
      wr(OFF_STATUS, 32'h0000_0006);
    end
    ir(OP_IDCODE);
    scan(KIND_DR, ID_W, '0, rx);
    `CHK(rx[ID_W-1:0], ID_CODE)
    rd(12'h100, st);
    `CHK({perr, st}, {1'b1, 32'h0000_0000})
    complete_run();
  end
endmodule : sram_boundary_scan_tap_tb_top
